// ### rtl/fault_defs.svh
// Register addresses, field positions, reset values and timing counts
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH
`define REG_COMMAND 7'h48
`define REG_CONFIG 7'h49
`define REG_PRESET_HI 7'h51
`define REG_PRESET_MID 7'h52
`define REG_PRESET_LO 7'h53
`define CMD_APPLY_PRESET 8'h02
`define CMD_RESET 8'h00
`define CFG_RESET 8'h20
`define PRESET_RESET 24'h00_0000
`define CFG_BIT_SEL 1
`define CFG_BIT_EN 2
`define CFG_BIT_CODE 5
`define CFG_BIT_DIR 6
`define CFG_USED_MASK 8'h66
`define POS_WIDTH 24
`define REF_CLK_HZ 20000000
`define FRAME_TIMEOUT_NS 16000
`define FRAME_TIMEOUT_CYC ((`FRAME_TIMEOUT_NS * (`REF_CLK_HZ / 1000000)) / 1000)
`endif

// ### rtl/fault_pkg.sv
// Types shared by the fault, position-hold and frame logic
package fault_pkg;
  typedef struct packed {
    logic valid;
    logic [23:0] value;
  } position_t;
  typedef struct packed {
    logic abs_ok;
    logic inc_ok;
    logic overspeed;
  } health_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT = 2'b10
  } frame_state_t;
endpackage

// ### rtl/pin_sync.sv
// Three-stage pin synchroniser with edge detection
`timescale 1ns/10ps
module pin_sync
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic agree;
  // First stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
        lvl_q <= s3_q;
    end
  end
  // A change counts only once the second and third stages agree, so one-cycle glitches vanish
  assign agree = (s2_q == s3_q);
  assign level = lvl_q;
  assign rise = agree & s3_q & ~lvl_q;
  assign fall = agree & ~s3_q & lvl_q;
endmodule

// ### rtl/encoder_fault_status.sv
// Fault flag, position hold and default registers of the serial readout
`timescale 1ns/10ps
`include "fault_defs.svh"
module encoder_fault_status
  import fault_pkg::*;
#(
  parameter int POS_BITS = `POS_WIDTH,
  parameter int TIMEOUT_CYC = `FRAME_TIMEOUT_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [23:0] decoded_pos,
  input wire logic decoded_valid,
  input wire logic inc_path_ok,
  input wire logic overspeed,
  input wire logic link_clk,
  input wire logic link_data_in,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_we,
  output logic [7:0] cfg_rdata,
  output logic link_data_out,
  output logic fault_flag_active_low,
  output logic [23:0] position_out,
  output logic [23:0] preset_value,
  output logic preset_apply,
  output logic preset_is_offset,
  output logic preset_enabled,
  output logic code_binary,
  output logic dir_inverted
);
  // The idle counter is 16 bits wide and the frame carries at most 24 position bits
  if (POS_BITS < 1 || POS_BITS > 24)
  begin
    $error("POS_BITS out of range");
  end
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535)
  begin
    $error("TIMEOUT_CYC out of range");
  end

  function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] cmd,
                                          input logic [7:0] cfg, input logic [23:0] pre);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `REG_COMMAND: r = cmd;
      `REG_CONFIG: r = cfg & `CFG_USED_MASK;
      `REG_PRESET_HI: r = pre[23:16];
      `REG_PRESET_MID: r = pre[15:8];
      `REG_PRESET_LO: r = pre[7:0];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // One decoded write strobe per register address
  function automatic logic reg_hit(input logic we, input logic [6:0] a, input logic [6:0] tgt);
    return we && (a == tgt);
  endfunction

  // Internal state
  logic [7:0] cmd_q;
  logic [7:0] cfg_q;
  logic [23:0] preset_q;
  logic [23:0] preset_act_q;
  logic apply_q;
  logic [7:0] rdata_q;
  position_t pos_q;
  health_t health;
  logic flag_q;
  logic [24:0] shift_q;
  logic [24:0] shift_d;
  logic dout_q;
  frame_state_t state_q;
  logic [15:0] idle_cnt_q;

  // Decoded strobes and selections
  logic sclk_level;
  logic sclk_rise;
  logic sclk_fall;
  logic din_level;
  logic cmd_wr;
  logic cfg_wr;
  logic apply_cmd;
  logic healthy;
  logic timeout_hit;
  logic pre_hi_wr;
  logic pre_mid_wr;
  logic pre_lo_wr;
  logic pos_take;
  logic [7:0] rdata_d;
  logic cfg_sel;
  logic cfg_en;
  logic cfg_code;
  logic cfg_dir;

  // Master clock is asynchronous to ref_clk and is only ever sampled
  pin_sync u_clk_sync
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(link_clk),
    .level(sclk_level),
    .rise(sclk_rise),
    .fall(sclk_fall)
  );

  // Receive line is synchronised though no frame field reads it yet
  pin_sync u_din_sync
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(link_data_in),
    .level(din_level),
    .rise(),
    .fall()
  );

  assign cmd_wr = reg_hit(cfg_we, cfg_addr, `REG_COMMAND);
  assign cfg_wr = reg_hit(cfg_we, cfg_addr, `REG_CONFIG);
  // Preset bytes land one at a time; none of them moves the active value
  assign pre_hi_wr = reg_hit(cfg_we, cfg_addr, `REG_PRESET_HI);
  assign pre_mid_wr = reg_hit(cfg_we, cfg_addr, `REG_PRESET_MID);
  assign pre_lo_wr = reg_hit(cfg_we, cfg_addr, `REG_PRESET_LO);
  assign apply_cmd = cmd_wr && (cfg_wdata == `CMD_APPLY_PRESET);
  // Health word: absolute path, incremental path, overspeed
  assign health = {decoded_valid, inc_path_ok, overspeed};
  // Any path fault or overspeed pulls the flag low; recovery needs nothing
  assign healthy = health.abs_ok & health.inc_ok & ~health.overspeed;
  // An overspeed sample is not trusted even when the decoder calls it valid
  assign pos_take = decoded_valid && !overspeed;
  // Stops at the limit so the count cannot wrap back into a live frame
  assign timeout_hit = (idle_cnt_q >= 16'(TIMEOUT_CYC));
  assign shift_d = {shift_q[23:0], 1'b0};
  assign rdata_d = read_mux(cfg_addr, cmd_q, cfg_q, preset_q);
  // Enable field is active low: 0 means enabled
  assign cfg_sel = cfg_q[`CFG_BIT_SEL];
  assign cfg_en = ~cfg_q[`CFG_BIT_EN];
  assign cfg_code = cfg_q[`CFG_BIT_CODE];
  assign cfg_dir = cfg_q[`CFG_BIT_DIR];

  // Register file with the documented defaults
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cmd_q <= `CMD_RESET;
      cfg_q <= `CFG_RESET;
      preset_q <= `PRESET_RESET;
    end
    else
    begin
      if (cmd_wr)
        cmd_q <= cfg_wdata;
      // Unused configuration bits are dropped on write so they always read 0
      if (cfg_wr)
        cfg_q <= cfg_wdata & `CFG_USED_MASK;
      if (pre_hi_wr)
        preset_q[23:16] <= cfg_wdata;
      if (pre_mid_wr)
        preset_q[15:8] <= cfg_wdata;
      if (pre_lo_wr)
        preset_q[7:0] <= cfg_wdata;
    end
  end

  // Written value stays inert until the apply command
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      preset_act_q <= `PRESET_RESET;
      apply_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      apply_q <= apply_cmd;
      if (apply_cmd)
        preset_act_q <= preset_q;
      rdata_q <= rdata_d;
    end
  end

  // Position hold and status flag; reset starts in alarm until a good read
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pos_q <= '0;
      flag_q <= 1'b0;
    end
    else
    begin
      if (pos_take)
      begin
        pos_q.value <= decoded_pos;
        pos_q.valid <= 1'b1;
      end
      flag_q <= healthy;
    end
  end

  // Frame: flag latched at frame start so it matches the frozen position
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      dout_q <= 1'b1;
      idle_cnt_q <= '0;
    end
    else
    begin
      // Clocks without a link edge; a master that stops mid-frame ends the frame
      if (sclk_rise || sclk_fall)
        idle_cnt_q <= '0;
      else if (!timeout_hit)
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      unique case (state_q)
        ST_IDLE:
        begin
          dout_q <= 1'b1;
          // Position and flag are frozen together at the first falling edge
          if (sclk_fall)
          begin
            shift_q <= {pos_q.value, flag_q};
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          // Rises beyond the 25th shift out zeros
          if (sclk_rise)
          begin
            dout_q <= shift_q[24];
            shift_q <= shift_d;
          end
          if (timeout_hit)
            state_q <= ST_WAIT;
        end
        // A clock still low here must not be taken as the start of a new frame
        ST_WAIT:
        begin
          dout_q <= 1'b1;
          if (sclk_level)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Every output is registered here so the pins never see decode glitches
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      fault_flag_active_low <= 1'b0;
      position_out <= '0;
      preset_value <= `PRESET_RESET;
      preset_apply <= 1'b0;
      preset_is_offset <= 1'b0;
      preset_enabled <= 1'b1;
      code_binary <= 1'b1;
      dir_inverted <= 1'b0;
      cfg_rdata <= 8'h00;
      link_data_out <= 1'b1;
    end
    else
    begin
      fault_flag_active_low <= flag_q;
      position_out <= pos_q.value;
      preset_value <= preset_act_q;
      preset_apply <= apply_q;
      preset_is_offset <= cfg_sel;
      preset_enabled <= cfg_en;
      code_binary <= cfg_code;
      dir_inverted <= cfg_dir;
      cfg_rdata <= rdata_q;
      link_data_out <= dout_q ^ (1'b0 & din_level);
    end
  end
endmodule

// ### sim/fault_chk.sv
// Assertions on the fault flag, position hold and registers
`timescale 1ns/10ps
`include "fault_defs.svh"
module fault_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic decoded_valid,
  input wire logic inc_path_ok,
  input wire logic overspeed,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_rdata,
  input wire logic fault_flag_active_low,
  input wire logic [23:0] position_out,
  input wire logic [23:0] preset_value,
  input wire logic preset_apply
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_good; decoded_valid && inc_path_ok && !overspeed; endsequence
  sequence s_cfg_wr; cfg_we && cfg_addr == `REG_CONFIG; endsequence
  sequence s_cfg_rd; cfg_addr == `REG_CONFIG && !cfg_we; endsequence
  property p_good; s_good [*3] |-> fault_flag_active_low; endproperty
  property p_abs; !decoded_valid |-> ##2 !fault_flag_active_low; endproperty
  property p_inc; !inc_path_ok |-> ##2 !fault_flag_active_low; endproperty
  property p_speed; overspeed |-> ##2 !fault_flag_active_low; endproperty
  // Three cycles cover the position pipeline before it must freeze
  property p_hold; !decoded_valid [*3] |-> $stable(position_out); endproperty
  property p_mask;
    s_cfg_wr ##1 s_cfg_rd [*3] |-> cfg_rdata == ($past(cfg_wdata, 3) & 8'h66);
  endproperty
  property p_apply;
    cfg_we && cfg_addr == `REG_COMMAND && cfg_wdata == 8'h02 |-> ##2 preset_apply;
  endproperty
  property p_pre; $changed(preset_value) |-> preset_apply; endproperty
  a_good: assert property (p_good) else $error("flag low while healthy");
  a_abs: assert property (p_abs) else $error("flag high, scale unread");
  a_inc: assert property (p_inc) else $error("flag high, AB fault");
  a_speed: assert property (p_speed) else $error("flag high, overspeed");
  a_hold: assert property (p_hold) else $error("position moved");
  a_mask: assert property (p_mask) else $error("config readback");
  a_apply: assert property (p_apply) else $error("no apply pulse");
  a_pre: assert property (p_pre) else $error("preset changed");
endmodule
bind encoder_fault_status fault_chk i_chk
(
  .ref_clk(ref_clk),
  .nrst(nrst),
  .decoded_valid(decoded_valid),
  .inc_path_ok(inc_path_ok),
  .overspeed(overspeed),
  .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata),
  .cfg_we(cfg_we),
  .cfg_rdata(cfg_rdata),
  .fault_flag_active_low(fault_flag_active_low),
  .position_out(position_out),
  .preset_value(preset_value),
  .preset_apply(preset_apply)
);

// ### sim/ssi_master_model.sv
// Serial master model that clocks one position frame out of the device
`timescale 1ns/10ps
module ssi_master_model (
  input wire logic go,
  input wire logic link_data_out,
  output logic link_clk,
  output logic [24:0] frame_q,
  output logic [23:0] trusted_q,
  output logic done
);
  initial
  begin
    link_clk = 1'b1;
    frame_q = '0;
    trusted_q = '0;
    done = 1'b0;
  end
  // Clock idles high between frames; the device needs up to five of its clocks to
  // answer a rise, so each bit is taken 300 ns after the rise that shifted it
  always @(posedge go)
  begin
    done = 1'b0;
    #13;
    link_clk = 1'b0;
    #200 link_clk = 1'b1;
    repeat (24)
    begin
      #200 link_clk = 1'b0;
      #100 frame_q = {frame_q[23:0], link_data_out};
      #100 link_clk = 1'b1;
    end
    #300 frame_q = {frame_q[23:0], link_data_out};
    if (frame_q[0])
      trusted_q = frame_q[24:1];
    done = 1'b1;
  end
endmodule

// ### sim/tb.sv
// Testbench: registers, fault flag, position hold and serial frame
`timescale 1ns/10ps
`include "fault_defs.svh"
module tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [23:0] decoded_pos = 24'h000000;
  logic decoded_valid = 1'b0;
  logic inc_path_ok = 1'b1;
  logic overspeed = 1'b0;
  logic [6:0] cfg_addr = 7'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_we = 1'b0;
  logic go = 1'b0;
  logic link_clk, link_data_out, fault_flag_active_low, done, preset_apply;
  logic preset_is_offset, preset_enabled, code_binary, dir_inverted;
  logic [7:0] cfg_rdata;
  logic [23:0] position_out, preset_value, trusted;
  logic [24:0] frame;
  int num_errors = 0;
  int total_checks = 0;
  encoder_fault_status #(.TIMEOUT_CYC(8)) i_dut
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .decoded_pos(decoded_pos),
    .decoded_valid(decoded_valid),
    .inc_path_ok(inc_path_ok),
    .overspeed(overspeed),
    .link_clk(link_clk),
    .link_data_in(1'b1),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_we(cfg_we),
    .cfg_rdata(cfg_rdata),
    .link_data_out(link_data_out),
    .fault_flag_active_low(fault_flag_active_low),
    .position_out(position_out),
    .preset_value(preset_value),
    .preset_apply(preset_apply),
    .preset_is_offset(preset_is_offset),
    .preset_enabled(preset_enabled),
    .code_binary(code_binary),
    .dir_inverted(dir_inverted)
  );
  ssi_master_model i_master (.go(go), .link_data_out(link_data_out), .link_clk(link_clk),
    .frame_q(frame), .trusted_q(trusted), .done(done));
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [24:0] seen, input logic [24:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic health(input logic v, input logic i, input logic o, input logic [23:0] p);
    @(posedge ref_clk);
    decoded_valid <= v;
    inc_path_ok <= i;
    overspeed <= o;
    decoded_pos <= p;
    cyc(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_we <= 1'b1;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    cfg_addr <= a;
    cyc(3);
    chk(n, {17'h0, cfg_rdata}, {17'h0, e});
  endtask
  task automatic read_frame(input logic [24:0] e);
    int n = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    cyc(2);
    while (done !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      num_errors++;
      close_out();
    end
    else
    begin
      @(posedge ref_clk);
      go <= 1'b0;
      cyc(12);
      chk("frame", frame, e);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(3);
    chk("flag", fault_flag_active_low, 1'b0);
    chk("cfg_out", {preset_is_offset, preset_enabled, code_binary, dir_inverted}, 4'h6);
    rdc("cmd", `REG_COMMAND, 8'h00);
    rdc("cfg", `REG_CONFIG, 8'h20);
    rdc("pre_hi", `REG_PRESET_HI, 8'h00);
    rdc("pre_lo", `REG_PRESET_LO, 8'h00);
    rdc("unmapped", 7'h50, 8'h00);
    health(1'b1, 1'b1, 1'b0, 24'h0186A0);
    chk("flag", fault_flag_active_low, 1'b1);
    chk("pos", position_out, 24'h0186A0);
    read_frame({24'h0186A0, 1'b1});
    health(1'b0, 1'b1, 1'b0, 24'h0F0F0F);
    chk("flag", fault_flag_active_low, 1'b0);
    chk("pos", position_out, 24'h0186A0);
    health(1'b1, 1'b1, 1'b1, 24'h123456);
    chk("flag", fault_flag_active_low, 1'b0);
    chk("pos", position_out, 24'h0186A0);
    health(1'b1, 1'b0, 1'b0, 24'h123456);
    chk("flag", fault_flag_active_low, 1'b0);
    chk("pos", position_out, 24'h123456);
    read_frame({24'h123456, 1'b0});
    chk("trusted", trusted, 24'h0186A0);
    health(1'b1, 1'b1, 1'b0, 24'h123456);
    chk("flag", fault_flag_active_low, 1'b1);
    wr(`REG_CONFIG, 8'hFF);
    rdc("cfg", `REG_CONFIG, 8'h66);
    chk("cfg_out", {preset_is_offset, preset_enabled, code_binary, dir_inverted}, 4'hB);
    wr(`REG_PRESET_HI, 8'h01);
    wr(`REG_PRESET_MID, 8'h86);
    wr(`REG_PRESET_LO, 8'hA0);
    cyc(4);
    chk("preset", preset_value, 24'h000000);
    wr(`REG_COMMAND, 8'h02);
    cyc(1);
    chk("apply", preset_apply, 1'b1);
    cyc(1);
    chk("apply", preset_apply, 1'b0);
    chk("preset", preset_value, 24'h0186A0);
    rdc("cmd", `REG_COMMAND, 8'h02);
    close_out();
  end
endmodule
